// ==== verilog/ifeb_pkg.sv ====
// Package of constants and types for the interrupt flag and enable bank.
package ifeb_pkg;
    localparam int ADDR_W = 16;
    localparam logic [15:0] PEND_OFFSET = 16'h4300;
    localparam logic [15:0] EN_OFFSET = 16'h4302;
    localparam logic [15:0] TRIG_OFFSET = 16'h4308;
    localparam logic [15:0] STAT_OFFSET = 16'h430A;
    localparam logic [15:0] MASK_OFFSET = 16'h430C;
    localparam logic [15:0] PEND_RESET = 16'h0000;
    localparam logic [15:0] EN_RESET = 16'h0000;
    localparam logic [7:0] TRIG_RESET = 8'h00;
    localparam logic [15:0] STAT_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam int NUM_SRC = 16;
    localparam int LOW_SRC = 8;
    localparam int PORT1_BIT = 1;
    localparam int I2C_BIT = 15;
    localparam int BYTE_TIMER_BIT = 8;
    localparam int PWM_BIT = 7;
    localparam int PORT0_BIT = 0;
    // Wishbone request bundle.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ADDR_W-1:0] adr;
        logic [31:0] dat;
    } ifeb_wb_req_t;
    // Bus acknowledge state.
    typedef enum logic [0:0] {
        IFEB_IDLE = 1'b0,
        IFEB_ACK = 1'b1
    } ifeb_bus_state_t;
endpackage

// ==== verilog/ifeb_flag_cell.sv ====
// One pending flag with pulse or level trigger behaviour.
`timescale 1ns/1ns
`default_nettype none
module ifeb_flag_cell #(
    parameter bit CLEARABLE_LEVEL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic src_event,
    input wire logic level_mode,
    input wire logic clear_write,
    output logic flag
);
    logic flag_q;
    logic flag_d;

    // Set wins over clear; in level mode without CLEARABLE_LEVEL the flag tracks the request.
    always_comb begin
        if (level_mode && !CLEARABLE_LEVEL) begin
            flag_d = src_event; // RULE4
        end else if (src_event) begin
            flag_d = 1'b1;
        end else if (clear_write) begin
            flag_d = 1'b0; // RULE3
        end else begin
            flag_d = flag_q;
        end
    end

    // Flag storage, cleared at reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0; // RULE5
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule
`default_nettype wire

// ==== verilog/ifeb_bank.sv ====
// Interrupt pending flag and source enable register bank on classic Wishbone.
// Summary of operation
// (RULE1) Upper byte flags for eight internal sources, set by source, cleared writing one.
// (RULE2) Lower byte flags for PWM, LCD, voltage, slow timer, clock, stopwatch, ports.
// (RULE3) Pulse mode lower flags clear when one is written, zero leaves them.
// (RULE4) Level mode lower flags ignore writes and follow the request level.
// (RULE5) All pending flags reset to zero; one means the cause occurred.
// (RULE6) Enable register, same bit layout as flags, read/write, resets to zero.
// (RULE7) Per lower source trigger select: one level, zero pulse, zero at reset.
// (RULE8) Request to CPU when flag and enable both set; flags set regardless.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module ifeb_bank (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [15:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [15:0] SRC_REQ,
    output logic CPU_IRQ,
    output logic IRQ_O
);
    ifeb_pkg::ifeb_wb_req_t req;
    ifeb_pkg::ifeb_bus_state_t st_q, st_d;
    logic [15:0] pend;
    logic [15:0] en_q, en_d;
    logic [7:0] trig_q, trig_d;
    logic [15:0] stat_q, stat_d;
    logic [15:0] mask_q, mask_d;
    logic [15:0] pend_prev_q;
    logic [31:0] rdat_q, rdat_d;
    logic wr_lo, wr_hi, take;
    logic [15:0] wdata, wmask, pend_clr;

    assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, sel: WB_SEL_I,
                   adr: WB_ADR_I, dat: WB_DAT_I};
    // A request is taken once, in the idle state; the ack follows one cycle later.
    assign take = req.cyc && req.stb && (st_q == ifeb_pkg::IFEB_IDLE);
    assign wr_lo = take && req.we && req.sel[0];
    assign wr_hi = take && req.we && req.sel[1];
    assign wdata = req.dat[15:0];
    assign wmask = {{8{wr_hi}}, {8{wr_lo}}};
    assign pend_clr = (req.adr == ifeb_pkg::PEND_OFFSET) ? (wdata & wmask) : 16'h0000;

    // Pending flags: upper byte always write-one clear, lower byte by trigger mode.
    genvar g;
    generate
        for (g = 0; g < ifeb_pkg::NUM_SRC; g++) begin : g_flag
            ifeb_flag_cell #(
                .CLEARABLE_LEVEL(g >= ifeb_pkg::LOW_SRC)
            ) u_cell (
                .clk(CORE_CLK),
                .rst(RST),
                .src_event(SRC_REQ[g]), // RULE1 RULE2
                .level_mode((g < ifeb_pkg::LOW_SRC) ? trig_q[g % 8] : 1'b0), // RULE7
                .clear_write(pend_clr[g]),
                .flag(pend[g])
            );
        end
    endgenerate

    // Register writes and read data; reads of unmapped offsets return zero.
    always_comb begin
        st_d = (take) ? ifeb_pkg::IFEB_ACK : ifeb_pkg::IFEB_IDLE;
        en_d = en_q;
        trig_d = trig_q;
        mask_d = mask_q;
        // New flag rises set sticky status; a write of one clears, set wins.
        stat_d = stat_q;
        if (req.adr == ifeb_pkg::STAT_OFFSET) begin
            stat_d = stat_q & ~(wdata & wmask);
        end
        stat_d = stat_d | (pend & ~pend_prev_q);
        rdat_d = rdat_q;
        if (take) begin
            rdat_d = 32'h0000_0000;
            unique case (req.adr)
                ifeb_pkg::PEND_OFFSET: rdat_d = {16'h0000, pend}; // RULE5
                ifeb_pkg::EN_OFFSET: rdat_d = {16'h0000, en_q};
                ifeb_pkg::TRIG_OFFSET: rdat_d = {24'h000000, trig_q};
                ifeb_pkg::STAT_OFFSET: rdat_d = {16'h0000, stat_q};
                ifeb_pkg::MASK_OFFSET: rdat_d = {16'h0000, mask_q};
                default: rdat_d = 32'h0000_0000;
            endcase
            if (req.adr == ifeb_pkg::EN_OFFSET) begin
                en_d = (en_q & ~wmask) | (wdata & wmask); // RULE6
            end
            if (req.adr == ifeb_pkg::TRIG_OFFSET && wr_lo) begin
                trig_d = wdata[7:0]; // RULE7
            end
            if (req.adr == ifeb_pkg::MASK_OFFSET) begin
                mask_d = (mask_q & ~wmask) | (wdata & wmask);
            end
        end
    end

    // Register storage.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st_q <= ifeb_pkg::IFEB_IDLE;
            en_q <= ifeb_pkg::EN_RESET; // RULE6
            trig_q <= ifeb_pkg::TRIG_RESET; // RULE7
            stat_q <= ifeb_pkg::STAT_RESET;
            mask_q <= ifeb_pkg::MASK_RESET;
            pend_prev_q <= ifeb_pkg::PEND_RESET;
            rdat_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
            en_q <= en_d;
            trig_q <= trig_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            pend_prev_q <= pend;
            rdat_q <= rdat_d;
        end
    end

    assign WB_ACK_O = (st_q == ifeb_pkg::IFEB_ACK);
    assign WB_DAT_O = rdat_q;
    // Request is a plain AND; flags keep setting while disabled.
    assign CPU_IRQ = |(pend & en_q); // RULE8
    assign IRQ_O = |(stat_q & mask_q);

    AST_ENABLE_WRITE: assert property (@(posedge CORE_CLK) disable iff (RST)
        take && req.we && req.adr == ifeb_pkg::EN_OFFSET && req.sel[1:0] == 2'b11
        |=> en_q == $past(wdata)) else $error("enable write lost"); // RULE6
    // The request must come through the flag cell, not only from the final AND.
    AST_IRQ_AND: assert property (@(posedge CORE_CLK) disable iff (RST)
        SRC_REQ[ifeb_pkg::I2C_BIT] && en_q[ifeb_pkg::I2C_BIT] && $stable(en_q)
        |=> CPU_IRQ) else $error("request mismatch"); // RULE8
    AST_UPPER_SET: assert property (@(posedge CORE_CLK) disable iff (RST)
        SRC_REQ[ifeb_pkg::I2C_BIT] |=> pend[ifeb_pkg::I2C_BIT])
        else $error("upper flag not set"); // RULE1
    AST_UPPER_CLR: assert property (@(posedge CORE_CLK) disable iff (RST)
        pend_clr[ifeb_pkg::BYTE_TIMER_BIT] && !SRC_REQ[ifeb_pkg::BYTE_TIMER_BIT]
        |=> !pend[ifeb_pkg::BYTE_TIMER_BIT]) else $error("upper clear failed"); // RULE1
    AST_LOW_SET: assert property (@(posedge CORE_CLK) disable iff (RST)
        SRC_REQ[ifeb_pkg::PWM_BIT] |=> pend[ifeb_pkg::PWM_BIT])
        else $error("lower flag not set"); // RULE2
    AST_PULSE_CLR: assert property (@(posedge CORE_CLK) disable iff (RST)
        pend_clr[ifeb_pkg::PORT0_BIT] && !trig_q[ifeb_pkg::PORT0_BIT]
        && !SRC_REQ[ifeb_pkg::PORT0_BIT] |=> !pend[ifeb_pkg::PORT0_BIT])
        else $error("pulse clear failed"); // RULE3
    AST_LEVEL_FOLLOW: assert property (@(posedge CORE_CLK) disable iff (RST)
        trig_q[ifeb_pkg::PORT1_BIT] && $stable(trig_q)
        |-> pend[ifeb_pkg::PORT1_BIT] == $past(SRC_REQ[ifeb_pkg::PORT1_BIT]))
        else $error("level flag not following"); // RULE4
    AST_NO_ZERO_CLR: assert property (@(posedge CORE_CLK) disable iff (RST)
        pend[ifeb_pkg::I2C_BIT] && !pend_clr[ifeb_pkg::I2C_BIT]
        |=> pend[ifeb_pkg::I2C_BIT]) else $error("flag lost without clear"); // RULE5
    AST_TRIG_WRITE: assert property (@(posedge CORE_CLK) disable iff (RST)
        wr_lo && req.adr == ifeb_pkg::TRIG_OFFSET |=> trig_q == $past(wdata[7:0]))
        else $error("trigger select write lost"); // RULE7
endmodule
`default_nettype wire

// ==== tb/ifeb_src_model.sv ====
// Behavioural model of the peripheral sources that raise interrupt requests.
`timescale 1ns/1ns
`default_nettype none
module ifeb_src_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] pulse_cmd,
    input wire logic [15:0] level_cmd,
    output logic [15:0] src_req
);
    // Pulse sources assert for one clock; level sources hold until the bench releases them.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_req <= 16'h0000;
        end else begin
            src_req <= pulse_cmd | level_cmd;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking testbench for the interrupt flag and enable bank.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [31:0] dat = 32'h00000000;
    logic [15:0] pls = 16'h0000;
    logic [15:0] lvl = 16'h0000;
    logic [15:0] req;
    logic [31:0] rdat;
    logic ack;
    logic cpu_irq;
    logic irq;
    logic [15:0] rd;
    int failures = 0;
    int cmp_count = 0;
    // Both byte lanes are always selected, so only whole registers are written.
    ifeb_bank ifeb_bank_i (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_SEL_I(4'h3), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .SRC_REQ(req), .CPU_IRQ(cpu_irq), .IRQ_O(irq));
    ifeb_src_model ifeb_src_model_i (.clk(clk), .rst(rst), .pulse_cmd(pls), .level_cmd(lvl),
        .src_req(req));
    // Clock runs at 125 MHz.
    always #4 clk = ~clk;
    // Ends the run with the counts and the verdict.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One classic cycle; the entry edge leaves the bus idle for a cycle between requests.
    task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat[15:0];
        if (n >= 20) failures++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [15:0] e, input string nm);
        bus(1'b0, a, 16'h0000);
        chk(nm, e, rd);
    endtask
    task automatic pulse(input logic [15:0] m);
        @(posedge clk);
        pls <= m;
        @(posedge clk);
        pls <= 16'h0000;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_reset();
        rdchk(ifeb_pkg::PEND_OFFSET, 16'h0000, "pending");
        rdchk(ifeb_pkg::EN_OFFSET, 16'h0000, "enables");
        bus(1'b1, ifeb_pkg::EN_OFFSET, 16'hA5C3);
        rdchk(ifeb_pkg::EN_OFFSET, 16'hA5C3, "enables");
        bus(1'b1, ifeb_pkg::EN_OFFSET, 16'h0000);
        rdchk(16'h4310, 16'h0000, "unmapped");
    endtask
    // Flags set while disabled; writing zero must leave the other flags alone.
    task automatic t_flags();
        pulse(16'hFFFF);
        rdchk(ifeb_pkg::PEND_OFFSET, 16'hFFFF, "pending");
        chk("cpu_irq", 16'h0000, {15'h0000, cpu_irq});
        bus(1'b1, ifeb_pkg::EN_OFFSET, 16'h8000);
        chk("cpu_irq", 16'h0001, {15'h0000, cpu_irq});
        bus(1'b1, ifeb_pkg::PEND_OFFSET, 16'h0001);
        rdchk(ifeb_pkg::PEND_OFFSET, 16'hFFFE, "pending");
        bus(1'b1, ifeb_pkg::PEND_OFFSET, 16'h8000);
        chk("cpu_irq", 16'h0000, {15'h0000, cpu_irq});
        bus(1'b1, ifeb_pkg::PEND_OFFSET, 16'hFFFF);
        rdchk(ifeb_pkg::PEND_OFFSET, 16'h0000, "pending");
    endtask
    // Port 1 in level mode ignores the clearing write and follows its source.
    task automatic t_level();
        bus(1'b1, ifeb_pkg::TRIG_OFFSET, 16'h0002);
        rdchk(ifeb_pkg::TRIG_OFFSET, 16'h0002, "trigger");
        lvl <= 16'h0002;
        repeat (3) @(posedge clk);
        bus(1'b1, ifeb_pkg::PEND_OFFSET, 16'h0002);
        rdchk(ifeb_pkg::PEND_OFFSET, 16'h0002, "pending");
        lvl <= 16'h0000;
        repeat (3) @(posedge clk);
        rdchk(ifeb_pkg::PEND_OFFSET, 16'h0000, "pending");
    endtask
    task automatic t_irq();
        rdchk(ifeb_pkg::STAT_OFFSET, 16'hFFFF, "status");
        bus(1'b1, ifeb_pkg::MASK_OFFSET, 16'h0001);
        rdchk(ifeb_pkg::MASK_OFFSET, 16'h0001, "mask");
        chk("irq", 16'h0001, {15'h0000, irq});
        bus(1'b1, ifeb_pkg::STAT_OFFSET, 16'hFFFF);
        rdchk(ifeb_pkg::STAT_OFFSET, 16'h0000, "status");
        chk("irq", 16'h0000, {15'h0000, irq});
    endtask
    // Main sequence after a two cycle reset.
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_flags();
        t_level();
        t_irq();
        print_verdict();
    end
    // Watchdog well beyond the roughly 80 cycles the tests need.
    initial begin
        #50000;
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
